// ---- bench/ccl_backup_model.sv ----
`timescale 1ns/1ps
module ccl_backup_model
(
   // host clock, paces the tick
   input  wire  clk,
   // pins of the fitted module
   output logic bkPresent,
   output logic bkBattLost,
   output logic bkCorrupt,
   output logic bkTick
);
   // fitted, good battery; tick rests low between seconds
   initial
   begin
      bkPresent  = 1'b1;
      bkBattLost = 1'b0;
      bkCorrupt  = 1'b0;
      bkTick     = 1'b0;
   end
   // fitting, battery loss and corruption on the bench's order
   task pins(input logic p, input logic b, input logic c);
      bkPresent  <= p;
      bkBattLost <= b;
      bkCorrupt  <= c;
   endtask
   // one crystal second squeezed to hi+lo cycles; long halves act slow
   task tick(input int hi, input int lo);
      bkTick <= 1'b1;
      repeat (hi) @(posedge clk);
      bkTick <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask
endmodule

// ---- bench/ccl_calendar_clock_monitor.sv ----
`timescale 1ns/1ps
module ccl_calendar_clock_monitor
#(
   parameter [31:0] SEC_CYCLES  = 32'h14,
   parameter [31:0] TRIM_WINDOW = 32'hA
)
(
   // clock, reset, enable
   input wire        clk,
   input wire        rst,
   input wire        ce,
   // register port
   input wire [3:0]  regAddr,
   input wire [31:0] regWdata,
   input wire        regWr,
   input wire        regRd,
   input wire [31:0] regRdata,
   // backup module pins
   input wire        bkPresent,
   input wire        bkBattLost,
   input wire        bkCorrupt,
   input wire        bkTick,
   // indicators
   input wire        clkFault,
   input wire        clkErrLed,
   input wire        irq
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // the light is the flag seen twice
   property p_led;
      clkErrLed == clkFault;
   endproperty
   a_led: assert property (p_led) else $error("light and fault differ");

   // read data stand one cycle only
   property p_idle;
      (ce && !regRd) |=> regRdata == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");

   // unmapped indices read as zero
   property p_unmap;
      (ce && regRd && regAddr > 4'hC) |=> regRdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");

   // a field read right after its write returns the written value
   property p_field;
      (ce && regWr && regAddr < 4'h7) ##1 (ce && regRd && regAddr == $past(regAddr))
         |=> regRdata[15:0] == $past(regWdata[15:0], 2);
   endproperty
   a_field: assert property (p_field) else $error("field readback wrong");

   // code bit 1 picks run or reload, bit 0 gives its new state
   property p_ctrl;
      (ce && regWr && regAddr == 4'h9 && regWdata < 32'h4) ##1 (ce && regRd && regAddr == 4'h9)
         |=> regRdata[$past(regWdata[1], 2)] == $past(regWdata[0], 2);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control readback wrong");

   // only reset clears the fault
   property p_sticky;
      clkFault |=> clkFault;
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault dropped");

   // lasting corruption must raise the fault past the synchronisers
   property p_corrupt;
      (ce && bkPresent && bkCorrupt) [*5] |=> clkFault;
   endproperty
   a_corrupt: assert property (p_corrupt) else $error("corruption missed");

   // missing module or lost battery seen at start-up
   property p_lost;
      $fell(rst) ##0 (ce && (!bkPresent || bkBattLost)) [*3] |=> clkFault;
   endproperty
   a_lost: assert property (p_lost) else $error("lost contents missed");
endmodule

bind ccl_calendar_clock ccl_calendar_clock_monitor
   #(.SEC_CYCLES(SEC_CYCLES), .TRIM_WINDOW(TRIM_WINDOW))
   i_mon (.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .bkPresent(bkPresent),
   .bkBattLost(bkBattLost), .bkCorrupt(bkCorrupt), .bkTick(bkTick),
   .clkFault(clkFault), .clkErrLed(clkErrLed), .irq(irq));

// ---- bench/ccl_calendar_clock_test.sv ----
`timescale 1ns/1ps
module ccl_calendar_clock_test;
   // short counts keep the run brief
   localparam SEC = 20;
   localparam TW  = 10;
   localparam TR  = 5;   // trim seconds per window
   localparam NT  = 4;   // backup ticks per trim pass
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;   // low only in the freeze test
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   wire  [31:0] regRdata;
   wire         bkPresent, bkBattLost, bkCorrupt, bkTick;
   wire         clkFault, clkErrLed, irq;
   int          errCount = 0;
   int          nChecks = 0;
   logic [31:0] d;          // last read data
   logic [1:0]  b;          // expected {reload, run}
   // written calendar, then the same one second later
   logic [15:0] tbl [3][14] = '{
      '{16'h07D0, 16'h2, 16'h1C, 16'h7, 16'h17, 16'h3B, 16'h3B,
        16'h07D0, 16'h2, 16'h1D, 16'h1, 16'h0, 16'h0, 16'h0},
      '{16'h0834, 16'h2, 16'h1C, 16'h3, 16'h17, 16'h3B, 16'h3B,
        16'h0834, 16'h3, 16'h1, 16'h4, 16'h0, 16'h0, 16'h0},
      '{16'h07CF, 16'hC, 16'h1F, 16'h5, 16'h17, 16'h3B, 16'h3B,
        16'h07D0, 16'h1, 16'h1, 16'h6, 16'h0, 16'h0, 16'h0}};

   always #2.5 clk = ~clk;

   ccl_calendar_clock #(.SEC_CYCLES(SEC), .TRIM_WINDOW(TW)) i_ccl_calendar_clock (
      .clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .bkPresent(bkPresent),
      .bkBattLost(bkBattLost), .bkCorrupt(bkCorrupt), .bkTick(bkTick),
      .clkFault(clkFault), .clkErrLed(clkErrLed), .irq(irq));
   ccl_backup_model i_ccl_backup_model (.clk(clk), .bkPresent(bkPresent),
      .bkBattLost(bkBattLost), .bkCorrupt(bkCorrupt), .bkTick(bkTick));

   // wait n edges; a write strobe left up by wr drops first
   task cyc(input int n);
      regWr <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // strobe left up at the end: back-to-back writes never assign it twice
   // in one time step, and whatever task follows lowers it
   task wr(input logic [3:0] a, input logic [31:0] v);
      regAddr  <= a;
      regWdata <= v;
      regWr    <= 1'b1;
      @(posedge clk);
   endtask
   // strobe taken at the first edge, data standing until the second
   task rd(input logic [3:0] a);
      regAddr <= a;
      regWr   <= 1'b0;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      @(posedge clk);
      d = regRdata;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      nChecks++;
      if (s !== e)
      begin
         errCount++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task chkb(input logic s, input logic e);
      chk({31'h0, s}, {31'h0, e});
   endtask
   task rc(input logic [3:0] a, input logic [15:0] e);
      rd(a);
      chk(d, {16'h0000, e});
   endtask
   task tk;
      regWr <= 1'b0;
      i_ccl_backup_model.tick(4, 4);
   endtask
   task reboot;
      rst <= 1'b1;
      cyc(6);
      rst <= 1'b0;
      cyc(1);
   endtask
   task done(input int k);
      $display("test %0d finished", k);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles needed
   initial
   begin
      #100000;
      errCount++;
      conclude;
   end

   initial
   begin
      reboot;
      // reset calendar, controls, unmapped place
      for (int i = 0; i < 7; i++)
         rc(i[3:0], tbl[2][7+i]);
      rd(4'hA);
      chk({28'h0, d[3:0]}, 32'h7);
      wr(4'hD, 32'h1234);
      rc(4'hD, 16'h0);
      b = 2'h3;
      for (int k = 0; k < 4; k++)
      begin
         wr(4'h9, 32'(k));
         b[k[1]] = k[0];
         rc(4'h9, {14'h0, b});
      end
      done(1);
      // carries through leap day, century and year end
      for (int c = 0; c < 3; c++)
      begin
         for (int i = 0; i < 7; i++)
         begin
            wr(i[3:0], {16'h0, tbl[c][i]});
            rc(i[3:0], tbl[c][i]);
         end
         wr(4'h7, 32'h0);
         rd(4'h7);
         chk(d, 32'h399B7);
         i_ccl_backup_model.tick(4 + 8 * c, 4 + 8 * c);
         for (int i = 0; i < 7; i++)
            rc(i[3:0], tbl[c][7+i]);
      end
      done(2);
      // status is sticky and cleared by its read; mask gates the line
      chkb(irq, 1'b0);
      rc(4'hB, 16'h1);
      wr(4'hC, 32'h1);
      tk;
      chkb(irq, 1'b1);
      rc(4'hB, 16'h1);
      chkb(irq, 1'b0);
      done(3);
      // stop, reload off, run, and the built-in source taking over
      wr(4'h9, 32'h0);
      wr(4'h9, 32'h2);
      wr(4'h6, 32'h0);
      cyc(3 * SEC);
      rc(4'h6, 16'h0);
      wr(4'h9, 32'h1);
      cyc(SEC + SEC / 2);
      rc(4'h6, 16'h1);
      // clock enable low freezes the prescaler and every field
      ce <= 1'b0;
      cyc(3 * SEC);
      ce <= 1'b1;
      rc(4'h6, 16'h1);
      wr(4'h9, 32'h0);
      wr(4'h9, 32'h3);
      wr(4'h9, 32'h1);
      wr(4'h6, 32'h0);
      cyc(3 * SEC);
      rc(4'h6, 16'h0);
      done(4);
      // trim both ways, spread as single seconds
      wr(4'h8, 32'(TR));
      wr(4'h6, 32'h0);
      repeat (NT) tk;
      rc(4'h6, 16'(NT + NT * TR / TW));
      wr(4'h8, 32'hFFFFFFFB);
      rd(4'h8);
      chk(d, 32'hFFFFFFFB);
      wr(4'h6, 32'h0);
      repeat (NT) tk;
      rc(4'h6, 16'(NT - NT * TR / TW));
      wr(4'h9, 32'h0);
      wr(4'h9, 32'h2);
      wr(4'h6, 32'h0);
      wr(4'h9, 32'h1);
      // two built-in seconds: a trimmed source would swallow the second one
      cyc(2 * SEC + SEC / 2);
      rc(4'h6, 16'h2);
      done(5);
      // corruption, then reload by software
      i_ccl_backup_model.pins(1'b1, 1'b0, 1'b1);
      cyc(8);
      chkb(clkFault, 1'b1);
      chkb(clkErrLed, 1'b1);
      rd(4'hB);
      chkb(d[1], 1'b1);
      wr(4'h6, 32'h5);
      rc(4'h6, 16'h5);
      chkb(clkFault, 1'b1);
      done(6);
      // start-up judgement of the backed contents
      i_ccl_backup_model.pins(1'b1, 1'b1, 1'b0);
      reboot;
      cyc(3);
      chkb(clkFault, 1'b1);
      i_ccl_backup_model.pins(1'b0, 1'b0, 1'b0);
      reboot;
      cyc(3);
      chkb(clkFault, 1'b1);
      i_ccl_backup_model.pins(1'b1, 1'b0, 1'b0);
      reboot;
      cyc(3);
      chkb(clkFault, 1'b0);
      done(7);
      conclude;
   end
endmodule

// ---- rtl/ccl_calendar_clock.v ----
`timescale 1ns/1ps
`include "ccl_consts.vh"

module ccl_calendar_clock
#(
   // cycles per second of the built-in source; shorten for simulation
   parameter [31:0] SEC_CYCLES = `CCL_SEC_NS / `CCL_CLK_NS,
   // length of the trim window in seconds; shorten for simulation
   parameter [31:0] TRIM_WINDOW = `CCL_TRIM_H * `CCL_S_PER_H
)
(
   // clock, reset, enable
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   // register port
   input  wire [3:0]  regAddr,
   input  wire [31:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdata,
   // backup clock module pins
   input  wire        bkPresent,
   input  wire        bkBattLost,
   input  wire        bkCorrupt,
   input  wire        bkTick,
   // indicators
   output reg         clkFault,
   output wire        clkErrLed,
   output wire        irq
);

   // calendar fields
   reg [15:0] year_reg;       // full year
   reg [15:0] month_reg;      // 1..12
   reg [15:0] day_reg;        // 1..31
   reg [15:0] wday_reg;       // 1..7
   reg [15:0] hour_reg;       // 0..23
   reg [15:0] min_reg;        // 0..59
   reg [15:0] sec_reg;        // 0..59
   reg [31:0] hms_reg;        // packed hhmmss
   reg [15:0] year_next;
   reg [15:0] month_next;
   reg [15:0] day_next;
   reg [15:0] wday_next;
   reg [15:0] hour_next;
   reg [15:0] min_next;
   reg [15:0] sec_next;

   // control
   reg        run_reg;        // clock running, from either source
   reg        auto_reg;       // follow backup module
   reg [15:0] trim_reg;       // signed trim seconds
   reg [31:0] trimAcc_reg;    // error accumulator
   reg        insPend_reg;    // extra second owed
   reg [31:0] pre_reg;        // built-in prescaler
   reg [1:0]  settle_reg;     // power-up sampling delay
   reg [1:0]  irqSt_reg;      // sticky events
   reg [1:0]  irqMsk_reg;     // event mask

   // synchronisers for the module pins
   reg [3:0]  sync1_reg;
   reg [3:0]  sync2_reg;
   reg        tickOld_reg;    // for edge detection on the clean copy

   wire presS    = sync2_reg[0];
   wire lostS    = sync2_reg[1];
   wire corruptS = sync2_reg[2];
   wire tickS    = sync2_reg[3];

   // leap year test
   function isLeap;
      input [15:0] y;
      begin
         isLeap = ((y % 16'h0004) == 16'h0000 && (y % 16'h0064) != 16'h0000)
                  || (y % 16'h0190) == 16'h0000;
      end
   endfunction

   // last day of a month
   function [15:0] monthLen;
      input [15:0] m;
      input [15:0] y;
      begin
         case (m)
            16'h0002: monthLen = isLeap(y) ? 16'h001D : 16'h001C;
            16'h0004, 16'h0006, 16'h0009, 16'h000B: monthLen = 16'h001E;
            default:  monthLen = 16'h001F;
         endcase
      end
   endfunction

   // packed decimal time
   function [31:0] packHms;
      input [15:0] h;
      input [15:0] m;
      input [15:0] s;
      begin
         packHms = {16'h0000, h} * 32'h0000_2710
                   + {16'h0000, m} * 32'h0000_0064
                   + {16'h0000, s};
      end
   endfunction

   // any write to a calendar field
   wire calWr = regWr && (regAddr <= `CCL_A_SECOND);
   // the backup module is the source while fitted and reload is on
   wire useBackup = presS && auto_reg;

   // built-in second strobe
   wire intTick = run_reg && (pre_reg == SEC_CYCLES - 32'h0000_0001);
   // backup second strobe, edge of the clean copy only
   wire bkEdge = tickS && !tickOld_reg;
   // raw tick before trimming
   wire baseTick = run_reg && (useBackup ? bkEdge : intTick);

   // trim magnitude and accumulator step
   wire        trimNeg = trim_reg[15];
   wire [15:0] trimMag = trimNeg ? (16'h0000 - trim_reg) : trim_reg;
   wire [31:0] accSum  = trimAcc_reg + {16'h0000, trimMag};
   // one correction due when the error reaches a whole window
   wire trimHit = useBackup && baseTick && (accSum >= TRIM_WINDOW);
   // a deletion swallows this tick; an insertion adds one later
   wire advance = !calWr && ((baseTick && !(trimHit && trimNeg)) || insPend_reg);

   // pin synchronisers
   always @(posedge clk)
   begin
      if (rst)
      begin
         sync1_reg   <= 4'h0;
         sync2_reg   <= 4'h0;
         tickOld_reg <= 1'b0;
      end
      else if (ce)
      begin
         sync1_reg   <= {bkTick, bkCorrupt, bkBattLost, bkPresent};
         sync2_reg   <= sync1_reg;
         tickOld_reg <= tickS;
      end
   end

   // built-in prescaler, held at zero while stopped, still counting while following the module
   always @(posedge clk)
   begin
      if (rst)
         pre_reg <= 32'h0000_0000;
      else if (ce)
      begin
         if (!run_reg || intTick)
            pre_reg <= 32'h0000_0000;
         else
            pre_reg <= pre_reg + 32'h0000_0001;
      end
   end

   // trim accumulator, Bresenham style so corrections are evenly spaced
   always @(posedge clk)
   begin
      if (rst)
      begin
         trimAcc_reg <= 32'h0000_0000;
         insPend_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (useBackup && baseTick)
            trimAcc_reg <= trimHit ? accSum - TRIM_WINDOW : accSum;
         // pending insert waits out a field write rather than being lost
         if (trimHit && !trimNeg)
            insPend_reg <= 1'b1;
         else if (advance)
            insPend_reg <= 1'b0;
      end
   end

   // one-second carry chain
   always @*
   begin
      year_next  = year_reg;
      month_next = month_reg;
      day_next   = day_reg;
      wday_next  = wday_reg;
      hour_next  = hour_reg;
      min_next   = min_reg;
      sec_next   = sec_reg + 16'h0001;
      // out-of-range values written by software roll over on the next carry
      if (sec_reg >= `CCL_MS_MAX)
      begin
         sec_next = 16'h0000;
         min_next = min_reg + 16'h0001;
         if (min_reg >= `CCL_MS_MAX)
         begin
            min_next  = 16'h0000;
            hour_next = hour_reg + 16'h0001;
            if (hour_reg >= `CCL_HOUR_MAX) // 24-hour wrap at midnight
            begin
               hour_next = 16'h0000;
               day_next  = day_reg + 16'h0001;
               // weekday advances with the date
               wday_next = (wday_reg >= `CCL_SUNDAY) ? `CCL_MONDAY
                           : wday_reg + 16'h0001;
               if (day_reg >= monthLen(month_reg, year_reg))
               begin
                  day_next   = 16'h0001;
                  month_next = month_reg + 16'h0001;
                  if (month_reg >= `CCL_DEC_MAX)
                  begin
                     month_next = 16'h0001;
                     year_next  = year_reg + 16'h0001;
                  end
               end
            end
         end
      end
   end

   // calendar registers: a write sets a field, otherwise the clock advances
   always @(posedge clk)
   begin
      if (rst)
      begin
         year_reg  <= `CCL_RST_YEAR;
         month_reg <= `CCL_RST_MONTH;
         day_reg   <= `CCL_RST_DAY;
         wday_reg  <= `CCL_RST_WDAY;
         hour_reg  <= 16'h0000;
         min_reg   <= 16'h0000;
         sec_reg   <= 16'h0000;
      end
      else if (ce)
      begin
         if (calWr)
         begin
            case (regAddr)
               `CCL_A_YEAR:   year_reg  <= regWdata[15:0];
               `CCL_A_MONTH:  month_reg <= regWdata[15:0];
               `CCL_A_DAY:    day_reg   <= regWdata[15:0];
               `CCL_A_WDAY:   wday_reg  <= regWdata[15:0];
               `CCL_A_HOUR:   hour_reg  <= regWdata[15:0];
               `CCL_A_MINUTE: min_reg   <= regWdata[15:0];
               default:       sec_reg   <= regWdata[15:0];
            endcase
         end
         else if (advance)
         begin
            year_reg  <= year_next;
            month_reg <= month_next;
            day_reg   <= day_next;
            wday_reg  <= wday_next;
            hour_reg  <= hour_next;
            min_reg   <= min_next;
            sec_reg   <= sec_next;
         end
      end
   end

   // packed time kept in a flop so the read mux stays shallow
   always @(posedge clk)
   begin
      if (rst)
         hms_reg <= 32'h0000_0000;
      else if (ce)
         hms_reg <= packHms(hour_reg, min_reg, sec_reg);
   end

   // control register: run/stop and backup reload codes
   always @(posedge clk)
   begin
      if (rst)
      begin
         run_reg  <= 1'b1;
         auto_reg <= 1'b1;
         trim_reg <= 16'h0000;
      end
      else if (ce && regWr)
      begin
         if (regAddr == `CCL_A_TRIM)
            trim_reg <= regWdata[15:0];
         if (regAddr == `CCL_A_CTRL)
         begin
            // codes above three are ignored
            if (regWdata[31:2] == 30'h0000_0000)
            begin
               case (regWdata[1:0])
                  `CCL_CMD_STOP:   run_reg  <= 1'b0;
                  `CCL_CMD_RUN:    run_reg  <= 1'b1;
                  `CCL_CMD_NOAUTO: auto_reg <= 1'b0;
                  default:         auto_reg <= 1'b1;
               endcase
            end
         end
      end
   end

   // fault flag: judged at power-up, raised later on corruption
   // only a reset (power cycle) clears it, and only if the module is sound
   always @(posedge clk)
   begin
      if (rst)
      begin
         settle_reg <= 2'h0;
         clkFault   <= 1'b0;
      end
      else if (ce)
      begin
         // wait for the synchronisers to fill before judging the pins
         if (settle_reg != `CCL_SETTLE)
            settle_reg <= settle_reg + 2'h1;
         if (settle_reg == `CCL_SETTLE - 2'h1 && (!presS || lostS))
            clkFault <= 1'b1;
         if (settle_reg == `CCL_SETTLE && presS && corruptS)
            clkFault <= 1'b1;
      end
   end

   assign clkErrLed = clkFault;

   // fault rising edge for the event register
   reg faultOld_reg;
   always @(posedge clk)
   begin
      if (rst)
         faultOld_reg <= 1'b0;
      else if (ce)
         faultOld_reg <= clkFault;
   end

   // sticky events: a read clears, but a new event in that cycle wins
   wire [1:0] evt = {clkFault && !faultOld_reg, advance};
   always @(posedge clk)
   begin
      if (rst)
      begin
         irqSt_reg  <= 2'h0;
         irqMsk_reg <= 2'h0;
      end
      else if (ce)
      begin
         if (regRd && regAddr == `CCL_A_IRQST)
            irqSt_reg <= evt;
         else
            irqSt_reg <= irqSt_reg | evt;
         if (regWr && regAddr == `CCL_A_IRQMSK)
            irqMsk_reg <= regWdata[1:0];
      end
   end

   // level interrupt while any unmasked event is pending
   assign irq = |(irqSt_reg & irqMsk_reg);

   // read mux; unmapped indices read zero
   reg [31:0] rdMux;
   always @*
   begin
      rdMux = 32'h0000_0000;
      case (regAddr)
         `CCL_A_YEAR:   rdMux = {16'h0000, year_reg};
         `CCL_A_MONTH:  rdMux = {16'h0000, month_reg};
         `CCL_A_DAY:    rdMux = {16'h0000, day_reg};
         `CCL_A_WDAY:   rdMux = {16'h0000, wday_reg};
         `CCL_A_HOUR:   rdMux = {16'h0000, hour_reg};
         `CCL_A_MINUTE: rdMux = {16'h0000, min_reg};
         `CCL_A_SECOND: rdMux = {16'h0000, sec_reg};
         `CCL_A_HMS:    rdMux = hms_reg;
         // trim reads back sign-extended
         `CCL_A_TRIM:   rdMux = {{16{trim_reg[15]}}, trim_reg};
         `CCL_A_CTRL:   rdMux = {30'h0000_0000, auto_reg, run_reg};
         `CCL_A_STAT:
         begin
            rdMux[`CCL_ST_RUN]   = run_reg;
            rdMux[`CCL_ST_AUTO]  = auto_reg;
            rdMux[`CCL_ST_PRES]  = presS;
            rdMux[`CCL_ST_FAULT] = clkFault;
            rdMux[`CCL_ST_SRC]   = useBackup;
         end
         `CCL_A_IRQST:  rdMux = {30'h0000_0000, irqSt_reg};
         `CCL_A_IRQMSK: rdMux = {30'h0000_0000, irqMsk_reg};
         default:       rdMux = 32'h0000_0000;
      endcase
   end

   // read data stands for exactly the cycle after the strobe
   always @(posedge clk)
   begin
      if (rst)
         regRdata <= 32'h0000_0000;
      else if (ce)
         regRdata <= regRd ? rdMux : 32'h0000_0000;
   end

endmodule

// ---- rtl/ccl_consts.vh ----
// Functional notes
// - keep year, month, day, weekday, hour, minute, second
// - auto-detect backup module, use it as source
// - no battery or >15 s lost: fault
// - corrupt backup contents: fault and error light
// - seven fields read and written as integers
// - year held as full four-digit value
// - weekday Monday 1 through Sunday 7
// - packed read equals hour*10000+minute*100+second
// - signed trim seconds per 72 hours
// - trim applies only to backup crystal source
// - control code 2/3 disables/enables backup reload
// - valid write plus power cycle clears fault; the code needs no write, a reset alone clears it
`ifndef CCL_CONSTS_VH
`define CCL_CONSTS_VH

// register indices on the plain bus
`define CCL_A_YEAR    4'h0
`define CCL_A_MONTH   4'h1
`define CCL_A_DAY     4'h2
`define CCL_A_WDAY    4'h3
`define CCL_A_HOUR    4'h4
`define CCL_A_MINUTE  4'h5
`define CCL_A_SECOND  4'h6
`define CCL_A_HMS     4'h7
`define CCL_A_TRIM    4'h8
`define CCL_A_CTRL    4'h9
`define CCL_A_STAT    4'hA
`define CCL_A_IRQST   4'hB
`define CCL_A_IRQMSK  4'hC

// hardware control codes
`define CCL_CMD_STOP   2'h0
`define CCL_CMD_RUN    2'h1
`define CCL_CMD_NOAUTO 2'h2
`define CCL_CMD_AUTO   2'h3

// status bit positions
`define CCL_ST_RUN   0
`define CCL_ST_AUTO  1
`define CCL_ST_PRES  2
`define CCL_ST_FAULT 3
`define CCL_ST_SRC   4

// interrupt bits
`define CCL_IRQ_SEC   0
`define CCL_IRQ_FAULT 1

// reset values of the calendar (2000-01-01, a Saturday)
`define CCL_RST_YEAR  16'h07D0
`define CCL_RST_MONTH 16'h0001
`define CCL_RST_DAY   16'h0001
`define CCL_RST_WDAY  16'h0006

// calendar limits
`define CCL_MONDAY   16'h0001
`define CCL_SUNDAY   16'h0007
`define CCL_HOUR_MAX 16'h0017
`define CCL_MS_MAX   16'h003B
`define CCL_DEC_MAX  16'h000C

// timing
`define CCL_CLK_NS     5
`define CCL_SEC_NS     1000000000
`define CCL_TRIM_H     72
`define CCL_S_PER_H    3600
`define CCL_BATT_S     15
`define CCL_SETTLE     2'h3
`endif
